// >>> design/ihp_cfg.svh
// ihp_cfg.svh: constants of the isa host port slave
// assumes inclusion by the port module only, not by design/ihp_pkg.sv
`ifndef IHP_CFG_SVH
`define IHP_CFG_SVH
`define IHP_MEM_BASE 20'h0_A000
`define IHP_MEM_MASK 20'hE_0000
`define IHP_MEM_MATCH 20'hA_0000
`define IHP_IO_MASK 20'h0_03E0
`define IHP_IO_MATCH 20'h0_03C0
`define IHP_MEM_WAIT 4'h3
`define IHP_BUS_SEL_ISA 1'h0
`define IHP_STRAP_RST 4'h0
`endif

// >>> design/ihp_pkg.sv
// ihp_pkg.sv: types of the isa host port slave
// assumes nothing; uses no constant of the cfg header
`default_nettype none
package ihp_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_MEM  = 4'b0010,
        ST_IO   = 4'b0100,
        ST_DONE = 4'b1000
    } ihp_state_t;
    typedef struct packed {
        ihp_state_t st;
        logic [3:0] waitCnt;
        logic [3:0] strap;
        logic isaMode;
        logic rstSeen;
        logic [7:0] dOut;
        logic dOe;
        logic rdyOe;
        logic zwsOe;
        logic irqLvl;
        logic irqOe;
        logic [19:0] addr;
        logic isRead;
        logic wrStb;
        logic [7:0] wrData;
    } ihp_regs_t;
endpackage
`default_nettype wire

// >>> design/ihp_port.sv
// ihp_port.sv: isa host bus slave port of a display controller
// assumes strobes synchronous to mclk; core supplies read data and retrace pulses
`timescale 1ns/1ps
`default_nettype none
`include "ihp_cfg.svh"
module ihp_port (
    input wire logic mclk,
    input wire logic rst,
    input wire logic suspend,
    input wire logic [19:0] hostAddr,
    input wire logic [7:0] hostDataIn,
    output logic [7:0] hostDataOut,
    output logic hostDataOe,
    input wire logic memory_decode_enable_in,
    input wire logic io_decode_enable_n,
    input wire logic ioRead_n,
    input wire logic ioWrite_n,
    input wire logic memRead_n,
    input wire logic memWrite_n,
    output logic readyOut,
    output logic readyOe,
    output logic zeroWaitOut_n,
    output logic zeroWaitOe,
    output logic irqOut,
    output logic irqOe,
    input wire logic [3:0] config_strap_bits,
    input wire logic bus_select_strap,
    output logic [3:0] strapLatched,
    output logic isaMode,
    input wire logic [7:0] coreRdData,
    output logic [19:0] coreAddr,
    output logic [7:0] coreWrData,
    output logic coreWrStrobe,
    input wire logic retracePulse,
    input wire logic irqEnable,
    input wire logic irqClear,
    input wire logic irqOutDisable
);
    import ihp_pkg::*;

    ihp_regs_t r;
    ihp_regs_t next_r;

    // gated inputs: suspend masks everything the host drives
    logic effRst, memCyc, ioCyc, memHit, ioHit;
    logic [19:0] aIn;
    logic [7:0] dIn;
    always_comb begin
        effRst = rst & ~suspend;
        aIn = suspend ? 20'h0_0000 : hostAddr;
        dIn = suspend ? 8'h00 : hostDataIn;
        memCyc = ~suspend & (~memRead_n | ~memWrite_n);
        ioCyc = ~suspend & (~ioRead_n | ~ioWrite_n);
        memHit = memCyc & memory_decode_enable_in & ((aIn & `IHP_MEM_MASK) == `IHP_MEM_MATCH);
        ioHit = ioCyc & ~io_decode_enable_n & ((aIn & `IHP_IO_MASK) == `IHP_IO_MATCH);
    end

    // one transfer machine; memory gets waits, io gets zero-wait
    always_comb begin
        next_r = r;
        // core write strobe lasts one cycle unless raised below
        next_r.wrStb = 1'b0;
        if (retracePulse && irqEnable) begin
            next_r.irqLvl = 1'b1;
        end else if (irqClear) begin
            next_r.irqLvl = 1'b0;
        end
        next_r.irqOe = ~irqOutDisable;
        case (r.st)
            ST_IDLE: begin
                next_r.rdyOe = 1'b0;
                next_r.zwsOe = 1'b0;
                next_r.dOe = 1'b0;
                if (memHit) begin
                    next_r.st = ST_MEM;
                    next_r.addr = aIn;
                    next_r.isRead = ~memRead_n;
                    next_r.waitCnt = `IHP_MEM_WAIT;
                    next_r.rdyOe = 1'b1;
                end else if (ioHit) begin
                    next_r.st = ST_IO;
                    next_r.addr = aIn;
                    next_r.isRead = ~ioRead_n;
                    next_r.zwsOe = 1'b1;
                    next_r.dOe = ~ioRead_n;
                    next_r.dOut = coreRdData;
                end
            end
            ST_MEM: begin
                if (r.waitCnt != 4'h0) begin
                    next_r.waitCnt = r.waitCnt - 4'h1;
                end else begin
                    next_r.rdyOe = 1'b0;
                    next_r.st = ST_DONE;
                    next_r.dOe = r.isRead;
                    next_r.dOut = coreRdData;
                    next_r.wrStb = ~r.isRead;
                    next_r.wrData = dIn;
                end
            end
            ST_IO: begin
                if (!ioCyc) begin
                    next_r.zwsOe = 1'b0;
                    next_r.dOe = 1'b0;
                    next_r.wrStb = ~r.isRead;
                    next_r.st = ST_IDLE;
                end else begin
                    next_r.wrData = dIn;
                end
            end
            ST_DONE: begin
                if (!memCyc) begin
                    next_r.dOe = 1'b0;
                    next_r.st = ST_IDLE;
                end
            end
            default: begin
                next_r.st = ST_IDLE;
            end
        endcase
        if (r.rstSeen) begin
            next_r.strap = config_strap_bits;
            next_r.isaMode = (bus_select_strap == `IHP_BUS_SEL_ISA);
        end
        next_r.rstSeen = 1'b0;
    end

    // single state register; reset loads ST_IDLE, sets rstSeen, clears all else and idles outputs
    always_ff @(posedge mclk) begin
        if (effRst) begin
            r <= '{st: ST_IDLE, waitCnt: 4'h0, strap: `IHP_STRAP_RST, isaMode: 1'b0,
                   rstSeen: 1'b1, dOut: 8'h00, dOe: 1'b0, rdyOe: 1'b0, zwsOe: 1'b0,
                   irqLvl: 1'b0, irqOe: 1'b0, addr: 20'h0_0000, isRead: 1'b0,
                   wrStb: 1'b0, wrData: 8'h00};
        end else begin
            r <= next_r;
        end
    end

    // outputs straight from flops; low levels used only when enabled
    assign hostDataOut = r.dOut;
    assign hostDataOe = r.dOe;
    assign readyOut = 1'b0;
    assign readyOe = r.rdyOe;
    assign zeroWaitOut_n = 1'b0;
    assign zeroWaitOe = r.zwsOe;
    assign irqOut = r.irqLvl;
    assign irqOe = r.irqOe;
    assign strapLatched = r.strap;
    assign isaMode = r.isaMode;
    assign coreAddr = r.addr;
    assign coreWrData = r.wrData;
    assign coreWrStrobe = r.wrStb;

    // checks: one clock; reset disables all but the two reset checks
    // never both
    property p_noBoth;
        @(posedge mclk) disable iff (rst) !(r.rdyOe && r.zwsOe);
    endproperty
    a_noBoth: assert property (p_noBoth) else $error("ready and zero-wait both driven");
    property p_oeOwner;
        @(posedge mclk) disable iff (rst) (!r.rdyOe || r.st == ST_MEM) && (!r.zwsOe || r.st == ST_IO);
    endproperty
    a_oeOwner: assert property (p_oeOwner) else $error("ready or zero-wait outside its cycle");
    property p_zwsIo;
        @(posedge mclk) disable iff (rst) (r.st == ST_IDLE && ioHit && !memHit) |=> r.zwsOe;
    endproperty
    a_zwsIo: assert property (p_zwsIo) else $error("zero-wait not driven on io hit");
    property p_zwsDrop;
        @(posedge mclk) disable iff (rst) (r.st == ST_IO && !ioCyc) |=> !r.zwsOe;
    endproperty
    a_zwsDrop: assert property (p_zwsDrop) else $error("zero-wait held after strobe release");
    property p_rdyMem;
        @(posedge mclk) disable iff (rst) (r.st == ST_IDLE && memHit) |=> r.rdyOe [*4] ##1 !r.rdyOe;
    endproperty
    a_rdyMem: assert property (p_rdyMem) else $error("ready wait length wrong");
    property p_rdyRel;
        @(posedge mclk) disable iff (rst) (r.st == ST_MEM && r.waitCnt == 4'h0) |=> !r.rdyOe;
    endproperty
    a_rdyRel: assert property (p_rdyRel) else $error("ready kept after transfer");
    property p_addr;
        @(posedge mclk) disable iff (rst) (r.st == ST_IDLE && memHit) |=> coreAddr == $past(hostAddr);
    endproperty
    a_addr: assert property (p_addr) else $error("memory address not taken");
    property p_refresh;
        @(posedge mclk) disable iff (rst) (r.st == ST_IDLE && !memory_decode_enable_in && !ioHit) |=> r.st == ST_IDLE;
    endproperty
    a_refresh: assert property (p_refresh) else $error("memory decoded during refresh");
    property p_ioGate;
        @(posedge mclk) disable iff (rst) (r.st == ST_IDLE && io_decode_enable_n && !memHit) |=> r.st == ST_IDLE;
    endproperty
    a_ioGate: assert property (p_ioGate) else $error("io decoded with io enable high");
    property p_susp;
        @(posedge mclk) disable iff (rst) (r.st == ST_IDLE && suspend) |=> r.st == ST_IDLE;
    endproperty
    a_susp: assert property (p_susp) else $error("strobe accepted in suspend");
    property p_irqSet;
        @(posedge mclk) disable iff (rst) (retracePulse && irqEnable) |=> irqOut;
    endproperty
    a_irqSet: assert property (p_irqSet) else $error("retrace did not raise irq");
    property p_irqHold;
        @(posedge mclk) disable iff (rst) (irqOut && !irqClear) |=> irqOut;
    endproperty
    a_irqHold: assert property (p_irqHold) else $error("irq dropped without clear");
    property p_irqClr;
        @(posedge mclk) disable iff (rst) (irqClear && !(retracePulse && irqEnable)) |=> !irqOut;
    endproperty
    a_irqClr: assert property (p_irqClr) else $error("irq kept after clear");
    property p_irqDis;
        @(posedge mclk) disable iff (rst) irqOutDisable |=> !irqOe;
    endproperty
    a_irqDis: assert property (p_irqDis) else $error("irq driven while disabled");
    property p_irqEn;
        @(posedge mclk) disable iff (rst) !irqOutDisable |=> irqOe;
    endproperty
    a_irqEn: assert property (p_irqEn) else $error("irq not driven while enabled");
    property p_dWrite;
        @(posedge mclk) disable iff (rst) (r.st != ST_IDLE && !r.isRead) |-> !hostDataOe;
    endproperty
    a_dWrite: assert property (p_dWrite) else $error("data driven on write");
    property p_dRead;
        @(posedge mclk) disable iff (rst) (r.st inside {ST_IO, ST_DONE} && r.isRead) |-> hostDataOe;
    endproperty
    a_dRead: assert property (p_dRead) else $error("data not driven on read");
    property p_wrPulse;
        @(posedge mclk) disable iff (rst) r.wrStb |=> !r.wrStb;
    endproperty
    a_wrPulse: assert property (p_wrPulse) else $error("core write strobe longer than one cycle");
    property p_strap;
        @(posedge mclk) disable iff (rst) r.rstSeen |=>
            strapLatched == $past(config_strap_bits) && isaMode == !$past(bus_select_strap);
    endproperty
    a_strap: assert property (p_strap) else $error("straps not taken after reset");
    property p_rstOut;
        @(posedge mclk) effRst |=> !(hostDataOe || readyOe || zeroWaitOe || irqOe || irqOut || coreWrStrobe);
    endproperty
    a_rstOut: assert property (p_rstOut) else $error("output active after reset");
    property p_suspRst;
        @(posedge mclk) (rst && suspend && irqOut && !irqClear) |=> irqOut;
    endproperty
    a_suspRst: assert property (p_suspRst) else $error("reset honoured during suspend");
    // scenario covers
    c_mem: cover property (@(posedge mclk) disable iff (rst) r.st == ST_MEM ##4 r.st == ST_DONE);
    c_ioWr: cover property (@(posedge mclk) disable iff (rst) r.st == ST_IO && !r.isRead ##1 r.wrStb);
    c_suspRst: cover property (@(posedge mclk) suspend && rst && irqOut);
    c_io: cover property (@(posedge mclk) disable iff (rst) r.st == ST_IO && r.isRead);
    c_irq: cover property (@(posedge mclk) disable iff (rst) irqOut ##1 !irqOut);
endmodule // ihp_port
`default_nettype wire

// >>> tb/ihp_host_model.sv
// ihp_host_model.sv: behavioural isa host that runs one bus cycle per task call
// assumes mclk from the bench; the bench calls cycle hierarchically
`timescale 1ns/1ps
`default_nettype none
module ihp_host_model (
    input wire logic mclk,
    output logic [19:0] hostAddr,
    output logic [7:0] hostDataIn,
    output logic ioRead_n,
    output logic ioWrite_n,
    output logic memRead_n,
    output logic memWrite_n,
    input wire logic [7:0] hostDataOut,
    input wire logic hostDataOe,
    input wire logic readyOe,
    input wire logic zeroWaitOe
);
    // idle bus: all strobes high
    initial begin
        hostAddr = 20'h0_0000;
        hostDataIn = 8'h00;
        {ioRead_n, ioWrite_n, memRead_n, memWrite_n} = 4'hF;
    end
    // gives up after 16 edges, which is how a refused cycle shows up
    task automatic cycle(input bit mem, input bit rd, input logic [19:0] a, input logic [7:0] wd,
                         output logic [7:0] rdv, output int waits, output bit zw);
        bit seen;
        seen = 0;
        waits = 0;
        zw = 0;
        rdv = 8'hxx;
        @(posedge mclk);
        hostAddr <= a;
        hostDataIn <= wd;
        {ioRead_n, ioWrite_n, memRead_n, memWrite_n} <= ~{!mem && rd, !mem && !rd, mem && rd, mem && !rd};
        for (int n = 0; n < 16; n++) begin
            @(posedge mclk);
            if (readyOe) begin
                seen = 1;
                waits++;
            end
            zw = zw | zeroWaitOe;
            if ((mem && seen && !readyOe) || (!mem && zeroWaitOe)) break;
        end
        if (hostDataOe) rdv = hostDataOut;
        // released lines show the inverse, never the stale value
        hostAddr <= ~a;
        hostDataIn <= ~wd;
        {ioRead_n, ioWrite_n, memRead_n, memWrite_n} <= 4'hF;
        @(posedge mclk);
    endtask
endmodule // ihp_host_model
`default_nettype wire

// >>> tb/ihp_port_bench.sv
// ihp_port_bench.sv: self-checking bench of the isa host port slave
// assumes the host model drives the bus; the bench plays core and straps
`timescale 1ns/1ps
`default_nettype none
module ihp_port_bench;
    logic mclk, rst, suspend, memory_decode_enable_in, io_decode_enable_n, ioRead_n, ioWrite_n, memRead_n;
    logic memWrite_n, hostDataOe, readyOe, zeroWaitOe, irqOut, irqOe, bus_select_strap, isaMode, coreWrStrobe;
    logic retracePulse, irqEnable, irqClear, irqOutDisable, readyOut, zeroWaitOut_n;
    logic [3:0] config_strap_bits, strapLatched;
    logic [7:0] hostDataIn, hostDataOut, coreRdData, coreWrData, rdv, lastWd;
    logic [19:0] hostAddr, coreAddr, lastWa;
    int mismatches, samples_checked, waits;
    bit zw;
    ihp_port dut_u (
        .mclk(mclk), .rst(rst), .suspend(suspend), .hostAddr(hostAddr), .hostDataIn(hostDataIn),
        .hostDataOut(hostDataOut), .hostDataOe(hostDataOe), .memory_decode_enable_in(memory_decode_enable_in),
        .io_decode_enable_n(io_decode_enable_n), .ioRead_n(ioRead_n), .ioWrite_n(ioWrite_n), .memRead_n(memRead_n),
        .memWrite_n(memWrite_n), .readyOut(readyOut), .readyOe(readyOe),
        .zeroWaitOut_n(zeroWaitOut_n), .zeroWaitOe(zeroWaitOe),
        .irqOut(irqOut), .irqOe(irqOe), .config_strap_bits(config_strap_bits), .bus_select_strap(bus_select_strap),
        .strapLatched(strapLatched), .isaMode(isaMode), .coreRdData(coreRdData), .coreAddr(coreAddr),
        .coreWrData(coreWrData), .coreWrStrobe(coreWrStrobe), .retracePulse(retracePulse), .irqEnable(irqEnable),
        .irqClear(irqClear), .irqOutDisable(irqOutDisable));
    ihp_host_model host_u (
        .mclk(mclk), .hostAddr(hostAddr), .hostDataIn(hostDataIn), .ioRead_n(ioRead_n), .ioWrite_n(ioWrite_n),
        .memRead_n(memRead_n), .memWrite_n(memWrite_n), .hostDataOut(hostDataOut), .hostDataOe(hostDataOe),
        .readyOe(readyOe), .zeroWaitOe(zeroWaitOe));
    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("checks=%0d mismatches=%0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // clock and a watchdog far beyond the some 130 cycles needed
    initial begin
        mclk = 0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        #20000;
        mismatches++;
        final_report();
    end
    // core write side, caught while it pulses
    always @(posedge mclk) begin
        if (coreWrStrobe === 1'b1) begin
            lastWa <= coreAddr;
            lastWd <= coreWrData;
        end
    end
    initial begin
        {rst, suspend, retracePulse, irqEnable, irqClear, irqOutDisable} = 6'h21;
        // enables stand in for refresh and address-enable lines
        {memory_decode_enable_in, io_decode_enable_n} = 2'h2;
        // bus-select strap pulled low through reset
        bus_select_strap = 1'b0;
        config_strap_bits = 4'hA;
        coreRdData = 8'h5A;
        repeat (3) @(posedge mclk);
        chk(20'({hostDataOe, readyOe, zeroWaitOe, irqOe, irqOut}), 20'h0_0000);
        rst <= 0;
        repeat (2) @(posedge mclk);
        chk(20'({strapLatched, isaMode}), 20'h0_0015);
        host_u.cycle(1, 1, 20'hA_0000, 8'h00, rdv, waits, zw);
        chk(20'({waits[3:0], zw, rdv}), 20'h0_085A);
        host_u.cycle(1, 0, 20'hB_FFFF, 8'h3C, rdv, waits, zw);
        repeat (2) @(posedge mclk);
        chk(20'(waits), 20'h0_0004);
        chk({lastWa[11:0], lastWd}, 20'hF_FF3C);
        coreRdData <= 8'hC3;
        host_u.cycle(0, 1, 20'h0_03DF, 8'h00, rdv, waits, zw);
        chk(20'({waits[3:0], zw, rdv}), 20'h0_01C3);
        host_u.cycle(0, 0, 20'h0_03C0, 8'h96, rdv, waits, zw);
        repeat (2) @(posedge mclk);
        chk({zw, lastWa[10:0], lastWd}, 20'hB_C096);
        // refresh, io enable high, then suspend on a memory and an io cycle
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk);
            memory_decode_enable_in <= (i != 0);
            io_decode_enable_n <= (i == 1);
            suspend <= (i >= 2);
            host_u.cycle(!i[0], 1, i[0] ? 20'h0_03C0 : 20'hA_0000, 8'h00, rdv, waits, zw);
            chk(20'(waits) + 20'(zw), 20'h0_0000);
        end
        @(posedge mclk) {suspend, io_decode_enable_n, retracePulse, irqOutDisable} <= 4'h0;
        @(posedge mclk) retracePulse <= 1;
        @(posedge mclk) retracePulse <= 0;
        repeat (2) @(posedge mclk);
        chk(20'({irqOut, irqOe}), 20'h0_0001);
        irqEnable <= 1;
        @(posedge mclk) retracePulse <= 1;
        @(posedge mclk) retracePulse <= 0;
        repeat (4) @(posedge mclk);
        chk(20'({irqOut, irqOe}), 20'h0_0003);
        {suspend, rst} <= 2'h3;
        repeat (3) @(posedge mclk);
        chk(20'({irqOut, irqOe}), 20'h0_0003);
        {suspend, rst, irqOutDisable} <= 3'h1;
        repeat (2) @(posedge mclk);
        chk(20'({irqOut, irqOe}), 20'h0_0002);
        @(posedge mclk) irqClear <= 1;
        @(posedge mclk) irqClear <= 0;
        @(posedge mclk);
        chk(20'(irqOut), 20'h0_0000);
        // mid-run reset with a pending irq; straps are taken again
        @(posedge mclk) retracePulse <= 1;
        @(posedge mclk) retracePulse <= 0;
        config_strap_bits <= 4'h5;
        rst <= 1;
        @(posedge mclk) rst <= 0;
        repeat (2) @(posedge mclk);
        chk(20'({strapLatched, isaMode, irqOut, irqOe}), 20'h0_002C);
        chk(20'({readyOut, zeroWaitOut_n}), 20'h0_0000);
        final_report();
    end
endmodule // ihp_port_bench
`default_nettype wire
